/* src/ddc_core.sv */
/*
 Down-converter core: four phase accumulators, mixer, five-stage
 decimation chain, two-entry output buffer and NCO synchronisation.
 Assumes settings come as steady levels from a register block on
 clk_sys; sync and SYSREF pins are asynchronous to clk_sys.
*/
`timescale 1ns/100ps
`include "ddc_map.svh"

module ddc_core
   import ddc_pkg::*;
(
   input  wire logic          clk_sys,                   // 20 MHz
   input  wire logic          sys_rst,                   // Async, high
   input  wire logic          clk_en,                    // Freeze when low
   input  wire logic [11:0]   adc_sample,                // Signed sample
   input  wire logic          adc_valid,                 // Sample present
   output logic               adc_ready,                 // Core accepts
   input  wire logic [2:0]    decim_mode,                // ddc_decim_t
   input  wire logic [127:0]  nco_freq_word_a,           // 4 x 32 bits
   input  wire logic [63:0]   nco_phase_offset_a,        // 4 x 16 bits
   input  wire logic [15:0]   rational_step_divider,     // 0 = basic
   input  wire logic [1:0]    nco_select,                // Active NCO
   input  wire logic          sync_on_link_init_enable,  // Sync pin method
   input  wire logic          sync_on_next_sysref_arm,   // Arm on rise
   input  wire logic          serial_link_enable,        // Link running
   input  wire logic          single_ended_sync_input_n, // Pin, low active
   input  wire logic          differential_sync_input_n, // Pin, low active
   input  wire logic          sync_use_differential,     // Pin choice
   input  wire logic          sysref_in,                 // Pin
   output logic [14:0]        out_i,                     // I or real
   output logic [14:0]        out_q,                     // Q, 0 in bypass
   output logic               out_valid,                 // Word present
   input  wire logic          out_ready,                 // Sink accepts
   output logic               cgs_start_request,         // Sync held low
   output logic               link_sync_armed,           // Awaits sync rise
   output logic               sysref_sync_armed,         // Awaits SYSREF
   output logic               nco_sync_pulse             // One cycle
);
   localparam logic [11:0] SIN_LUT [32] = '{
      12'h000, 12'h064, 12'h0c9, 12'h12c, 12'h18f, 12'h1f1, 12'h252,
      12'h2b2, 12'h30f, 12'h36b, 12'h3c5, 12'h41c, 12'h471, 12'h4c3,
      12'h513, 12'h55f, 12'h5a7, 12'h5ed, 12'h62e, 12'h66c, 12'h6a6,
      12'h6dc, 12'h70d, 12'h73a, 12'h763, 12'h787, 12'h7a7, 12'h7c2,
      12'h7d8, 12'h7eb, 12'h7f5, 12'h7fd};

   function automatic logic signed [47:0] rne(
      input logic signed [47:0] v, input int sh);
      logic signed [47:0] q;
      logic [47:0]        fr;
      logic [47:0]        hf;
      q  = v >>> sh;
      fr = v & ((48'h1 << sh) - 48'h1);
      hf = 48'h1 << (sh - 1);
      if (fr > hf || (fr == hf && q[0]))
         q = q + 48'sh1;
      return q;
   endfunction

   function automatic logic signed [47:0] sat(
      input logic signed [47:0] v, input int w);
      logic signed [47:0] mx;
      mx = (48'sh1 <<< (w - 1)) - 48'sh1;
      if (v > mx)
         return mx;
      if (v < -mx - 48'sh1)
         return -mx - 48'sh1;
      return v;
   endfunction

   // Quarter-wave table; a 7-bit phase keeps the table small at a
   // spur cost well above the 12-bit sample floor
   function automatic logic signed [11:0] sin12(input logic [6:0] p);
      logic [5:0]  k;
      logic [11:0] m;
      k = p[5] ? 6'h20 - {1'b0, p[4:0]} : {1'b0, p[4:0]};
      m = k[5] ? 12'h7ff : SIN_LUT[k[4:0]];
      return p[6] ? signed'(-m) : signed'(m);
   endfunction

   // ---------------- Synchronisers and sync control ----------------
   logic sy1_reg, sy2_reg, sy3_reg;
   logic sr1_reg, sr2_reg, sr3_reg;
   logic arm_prev_reg;
   logic link_armed_reg, sysref_armed_reg;
   logic sync_pulse_reg, cgs_reg;

   wire sync_pin    = sync_use_differential ? differential_sync_input_n
                                            : single_ended_sync_input_n;
   wire sync_low    = ~sy2_reg;
   wire sync_rise   = sy2_reg & ~sy3_reg;
   wire sysref_rise = sr2_reg & ~sr3_reg;
   wire arm_rise    = sync_on_next_sysref_arm & ~arm_prev_reg;
   wire evt_link    = link_armed_reg & sync_rise;
   wire evt_sysref  = sysref_armed_reg & sysref_rise;
   wire sync_evt    = evt_link | evt_sysref;
   // Encoding is not looked at: the pin method works in any mode
   wire link_armed_next = (sync_on_link_init_enable & serial_link_enable
                           & sync_low)
                        | (link_armed_reg & ~evt_link
                           & sync_on_link_init_enable);
   // A fresh arm wins over the SYSREF edge that fires the old one
   wire sysref_armed_next = arm_rise
                          | (sysref_armed_reg & ~evt_sysref
                             & sync_on_next_sysref_arm);

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sy1_reg <= 1'b1;
         sy2_reg <= 1'b1;
         sy3_reg <= 1'b1;
         sr1_reg <= 1'b0;
         sr2_reg <= 1'b0;
         sr3_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         sy1_reg <= sync_pin;
         sy2_reg <= sy1_reg;
         sy3_reg <= sy2_reg;
         sr1_reg <= sysref_in;
         sr2_reg <= sr1_reg;
         sr3_reg <= sr2_reg;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         arm_prev_reg     <= 1'b0;
         link_armed_reg   <= 1'b0;
         sysref_armed_reg <= 1'b0;
         sync_pulse_reg   <= 1'b0;
         cgs_reg          <= 1'b0;
      end
      else if (clk_en)
      begin
         arm_prev_reg     <= sync_on_next_sysref_arm;
         link_armed_reg   <= link_armed_next;
         sysref_armed_reg <= sysref_armed_next;
         sync_pulse_reg   <= sync_evt;
         cgs_reg          <= serial_link_enable & sync_low;
      end
   end

   // ---------------- Phase accumulators ----------------
   wire        rational  = rational_step_divider != 16'h0;
   wire [15:0] rdiv_safe = rational ? rational_step_divider : 16'h1;
   logic [31:0] nco_phase [4];

   for (genvar n = 0; n < `DDC_NCO_N; n++)
   begin : g_nco
      logic [31:0] acc_reg;
      logic [15:0] rem_reg;
      wire [31:0] fw  = nco_freq_word_a[n*32 +: 32];
      wire [15:0] off = nco_phase_offset_a[n*16 +: 16];
      // Step count recovered from the rounded word
      wire [47:0] nw  = 48'(fw) * 48'(rational_step_divider)
                      + `DDC_RDIV_HALF;
      wire [47:0] num = {nw[47:`DDC_RDIV_SHIFT], 26'h0};
      wire [47:0] inc = num / 48'(rdiv_safe);
      wire [47:0] rmd = num % 48'(rdiv_safe);
      wire [16:0] rsum  = {1'b0, rem_reg} + {1'b0, rmd[15:0]};
      wire        carry = rsum >= {1'b0, rational_step_divider};
      wire [16:0] rnext = carry ? rsum - {1'b0, rational_step_divider}
                                : rsum;
      // Exact step multiples via remainder carry
      wire [31:0] step = rational ? inc[31:0] + {31'h0, carry}
                                  : fw;
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
         if (sys_rst)
         begin
            acc_reg <= 32'h0;
            rem_reg <= 16'h0;
         end
         else if (clk_en)
         begin
            if (sync_evt)
            begin
               acc_reg <= 32'h0;
               rem_reg <= 16'h0;
            end
            else
            begin
               acc_reg <= acc_reg + step;
               rem_reg <= rational ? rnext[15:0] : 16'h0;
            end
         end
      end
      assign nco_phase[n] = acc_reg + {off, 16'h0};
   end

   // ---------------- Mixer ----------------
   logic              ready_reg;
   wire               dp_run   = clk_en & ready_reg;
   wire               bypass   = decim_mode == DDC_BYPASS;
   wire [31:0]        sel_ph   = nco_phase[nco_select];
   wire signed [11:0] nco_sin  = sin12(sel_ph[31:25]);
   wire signed [11:0] nco_cos  = sin12(sel_ph[31:25] + `DDC_QUARTER);
   wire signed [47:0] prod_i   = 48'(signed'(adc_sample)) * 48'(nco_cos);
   wire signed [47:0] prod_q   = 48'(signed'(adc_sample)) * 48'(nco_sin);
   logic signed [17:0] st_i [6];
   logic signed [17:0] st_q [6];
   logic               st_v [6];
   logic [11:0]        raw_reg;
   logic               mix_v_reg;
   logic signed [17:0] mix_i_reg, mix_q_reg;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         raw_reg   <= 12'h0;
         mix_v_reg <= 1'b0;
         mix_i_reg <= 18'sh0;
         mix_q_reg <= 18'sh0;
      end
      else if (dp_run)
      begin
         mix_v_reg <= adc_valid;
         if (adc_valid)
         begin
            raw_reg   <= adc_sample;
            mix_i_reg <= 18'(rne(prod_i, `DDC_MIX_SHIFT));
            mix_q_reg <= 18'(rne(prod_q, `DDC_MIX_SHIFT));
         end
      end
   end

   assign st_i[0] = mix_i_reg;
   assign st_q[0] = mix_q_reg;
   assign st_v[0] = mix_v_reg;

   // ---------------- Decimation chain ----------------
   // Inactive stages pass straight through
   wire [2:0] first_stage = 3'h4 - decim_mode;

   for (genvar s = 0; s < `DDC_STAGE_N; s++)
   begin : g_stage
      localparam int C  = CTR[s];
      localparam int NT = 2 * C + 1;
      localparam int SH = SHF[s];
      logic signed [17:0] li_reg [NT];
      logic signed [17:0] lq_reg [NT];
      logic               ph_reg, emit_reg, ov_reg;
      logic signed [17:0] oi_reg, oq_reg;
      logic signed [47:0] si, sq;
      wire act  = 3'(s) >= first_stage;
      wire take = st_v[s] & act;

      // Folded sum; symmetry halves the multipliers
      always_comb
      begin
         si = 48'(li_reg[C]) * 48'(ddc_coef(s, C));
         sq = 48'(lq_reg[C]) * 48'(ddc_coef(s, C));
         for (int k = 0; k < C; k++)
         begin
            si = si + (48'(li_reg[k]) + 48'(li_reg[NT-1-k]))
                    * 48'(ddc_coef(s, k));
            sq = sq + (48'(lq_reg[k]) + 48'(lq_reg[NT-1-k]))
                    * 48'(ddc_coef(s, k));
         end
      end

      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
         if (sys_rst)
         begin
            for (int k = 0; k < NT; k++)
            begin
               li_reg[k] <= 18'sh0;
               lq_reg[k] <= 18'sh0;
            end
            ph_reg   <= 1'b0;
            emit_reg <= 1'b0;
            ov_reg   <= 1'b0;
            oi_reg   <= 18'sh0;
            oq_reg   <= 18'sh0;
         end
         else if (dp_run)
         begin
            if (take)
            begin
               for (int k = NT - 1; k > 0; k--)
               begin
                  li_reg[k] <= li_reg[k-1];
                  lq_reg[k] <= lq_reg[k-1];
               end
               li_reg[0] <= st_i[s];
               lq_reg[0] <= st_q[s];
               ph_reg    <= ~ph_reg;
            end
            emit_reg <= take & ph_reg;
            ov_reg   <= emit_reg;
            if (emit_reg)
            begin
               oi_reg <= 18'(sat(rne(si, SH), `DDC_MIX_W));
               oq_reg <= 18'(sat(rne(sq, SH), `DDC_MIX_W));
            end
         end
      end

      assign st_i[s+1] = act ? oi_reg : st_i[s];
      assign st_q[s+1] = act ? oq_reg : st_q[s];
      assign st_v[s+1] = act ? ov_reg : st_v[s];
   end

   // ---------------- Output buffer ----------------
   wire [47:0] fin_i = sat(rne(48'(st_i[5]), `DDC_FINAL_SHIFT), `DDC_OUT_W);
   wire [47:0] fin_q = sat(rne(48'(st_q[5]), `DDC_FINAL_SHIFT), `DDC_OUT_W);
   wire [14:0] bin_i = bypass ? {{3{raw_reg[11]}}, raw_reg}
                              : fin_i[14:0];
   wire [14:0] bin_q = bypass ? 15'h0 : fin_q[14:0];
   wire        bin_v = bypass ? mix_v_reg : st_v[5];

   logic [14:0] hi_reg, hq_reg, ti_reg, tq_reg;
   logic        hv_reg, tv_reg;
   wire push = clk_en & bin_v & ready_reg;
   wire pop  = clk_en & hv_reg & out_ready;
   wire hv_next = pop ? (tv_reg | push) : (hv_reg | push);
   wire tv_next = pop ? (tv_reg & push) : (tv_reg | (hv_reg & push));

   // Ready comes from the full flag so the mixer and decimation stages stall
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hi_reg    <= 15'h0;
         hq_reg    <= 15'h0;
         ti_reg    <= 15'h0;
         tq_reg    <= 15'h0;
         hv_reg    <= 1'b0;
         tv_reg    <= 1'b0;
         ready_reg <= 1'b1;
      end
      else if (clk_en)
      begin
         if ((pop && tv_reg))
         begin
            hi_reg <= ti_reg;
            hq_reg <= tq_reg;
         end
         else if (push && (pop || !hv_reg))
         begin
            hi_reg <= bin_i;
            hq_reg <= bin_q;
         end
         if (push && hv_reg && (tv_reg || !pop))
         begin
            ti_reg <= bin_i;
            tq_reg <= bin_q;
         end
         hv_reg    <= hv_next;
         tv_reg    <= tv_next;
         ready_reg <= ~(hv_next & tv_next);
      end
   end

   assign adc_ready         = ready_reg;
   assign out_i             = hi_reg;
   assign out_q             = hq_reg;
   assign out_valid         = hv_reg;
   assign cgs_start_request = cgs_reg;
   assign link_sync_armed   = link_armed_reg;
   assign sysref_sync_armed = sysref_armed_reg;
   assign nco_sync_pulse    = sync_pulse_reg;
endmodule

/* src/ddc_map.svh */
/*
 Widths, shifts and counts of the down-converter core.
 Assumes inclusion by the core alone, by bare name.
*/
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH
`define DDC_ADC_W        12
`define DDC_MIX_W        18
`define DDC_OUT_W        15
`define DDC_FREQ_W       32
`define DDC_PHASE_W      16
`define DDC_NCO_N        4
`define DDC_RDIV_W       16
`define DDC_RDIV_SHIFT   26
`define DDC_RDIV_HALF    48'h2000000
`define DDC_RDIV_ADVISED 16'h2000
`define DDC_STAGE_N      5
`define DDC_MIX_SHIFT    5
`define DDC_FINAL_SHIFT  3
`define DDC_QUARTER      7'h20
`endif

/* src/ddc_pkg.sv */
/*
 Types and filter coefficient tables of the down-converter core.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ddc_pkg;
   typedef enum logic [2:0] {
      DDC_BYPASS = 3'h0,
      DDC_DEC4   = 3'h1,
      DDC_DEC8   = 3'h2,
      DDC_DEC16  = 3'h3,
      DDC_DEC32  = 3'h4
   } ddc_decim_t;

   typedef logic signed [19:0] ddc_coef_t;

   // Nonzero side taps only; odd distances from the ends are zero
   localparam ddc_coef_t NZ0 [2] = '{-20'sh1, 20'sh9};
   localparam ddc_coef_t NZ1 [2] = '{-20'sh41, 20'sh241};
   localparam ddc_coef_t NZ2 [3] = '{20'sh6d, -20'sh345, 20'sh12d8};
   localparam ddc_coef_t NZ3 [4] = '{-20'sh147, 20'sh8b7, -20'sh22b1,
                                     20'sh9b3e};
   localparam ddc_coef_t NZ4 [14] = '{-20'sh25, 20'sh76, -20'sh123,
      20'sh264, -20'sh487, 20'sh7ef, -20'shd1c, 20'sh14bc, -20'sh1fcc,
      20'sh2ffc, -20'sh48c4, 20'sh730f, -20'shcfc7, 20'sh288ab};
   localparam ddc_coef_t CEN [5] = '{20'sh10, 20'sh400, 20'sh2000,
                                     20'sh10000, 20'sh40000};
   localparam int CTR [5] = '{3, 3, 5, 7, 27};
   localparam int SHF [5] = '{5, 11, 14, 17, 19};

   function automatic ddc_coef_t ddc_coef(input int s, input int k);
      ddc_coef_t v;
      v = 20'sh0;
      if (k == CTR[s])
         v = CEN[s];
      else if (k % 2 == 0)
      begin
         case (s)
            0: v = NZ0[k/2];
            1: v = NZ1[k/2];
            2: v = NZ2[k/2];
            3: v = NZ3[k/2];
            default: v = NZ4[k/2];
         endcase
      end
      return v;
   endfunction
endpackage

/* tb/ddc_core_chk.sv */
/*
 Checker for ddc_core: output stall, sync arming and pulse timing.
 Assumes it is bound to ddc_core; one clock, reset active high.
*/
`timescale 1ns/100ps
module ddc_core_chk
(
   input wire logic        clk_sys,                   // Clock
   input wire logic        sys_rst,                   // Reset
   input wire logic        clk_en,                    // Run
   input wire logic        adc_ready,                 // Core accepts
   input wire logic [14:0] out_i,                     // I word
   input wire logic [14:0] out_q,                     // Q word
   input wire logic        out_valid,                 // Word present
   input wire logic        out_ready,                 // Sink accepts
   input wire logic        sync_on_link_init_enable,  // Pin method
   input wire logic        serial_link_enable,        // Link on
   input wire logic        single_ended_sync_input_n, // Pin
   input wire logic        differential_sync_input_n, // Pin
   input wire logic        sync_use_differential,     // Pin choice
   input wire logic        sync_on_next_sysref_arm,   // Arm bit
   input wire logic        sysref_in,                 // Pin
   input wire logic        cgs_start_request,         // Link request
   input wire logic        link_sync_armed,           // Armed flag
   input wire logic        sysref_sync_armed,         // Armed flag
   input wire logic        nco_sync_pulse             // Sync pulse
);
   wire sync_n = sync_use_differential ? differential_sync_input_n
                                       : single_ended_sync_input_n;
   wire link_go = clk_en && sync_on_link_init_enable && serial_link_enable;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   out_hold_a: assert property (
      out_valid && !out_ready && clk_en |=>
      out_valid && $stable(out_i) && $stable(out_q))
      else $error("output word changed while stalled");
   ready_full_a: assert property (!adc_ready |-> out_valid)
      else $error("input refused with empty output");
   link_arm_a: assert property (
      (link_go && !sync_n) [*4] |-> link_sync_armed)
      else $error("sync held low did not arm");
   cgs_req_a: assert property (
      (clk_en && serial_link_enable && !sync_n) [*4] |-> cgs_start_request)
      else $error("sync held low gave no link request");
   link_fire_a: assert property (
      link_sync_armed && link_go && $rose(sync_n) |-> ##[1:4] nco_sync_pulse)
      else $error("sync release gave no pulse");
   pulse_one_a: assert property (nco_sync_pulse |=> !nco_sync_pulse)
      else $error("sync pulse longer than one cycle");
   pulse_cause_a: assert property (
      nco_sync_pulse |-> $past(link_sync_armed) || $past(sysref_sync_armed))
      else $error("sync pulse without arming");
   sysref_arm_a: assert property (
      clk_en && $rose(sync_on_next_sysref_arm) |=> sysref_sync_armed)
      else $error("arm bit rise did not arm");
   arm_drop_a: assert property (
      clk_en && !sync_on_next_sysref_arm |=> !sysref_sync_armed)
      else $error("armed flag kept after arm bit dropped");
   sysref_fire_a: assert property (
      sysref_sync_armed && sync_on_next_sysref_arm && $rose(sysref_in)
      |-> ##[1:4] nco_sync_pulse)
      else $error("armed sysref edge gave no pulse");

   cover property (nco_sync_pulse && $past(link_sync_armed));
   cover property (nco_sync_pulse && $past(sysref_sync_armed));
   cover property (!adc_ready);
endmodule

bind ddc_core ddc_core_chk u_chk
(
   .clk_sys, .sys_rst, .clk_en, .adc_ready, .out_i, .out_q, .out_valid,
   .out_ready, .sync_on_link_init_enable, .serial_link_enable,
   .single_ended_sync_input_n, .differential_sync_input_n,
   .sync_use_differential, .sync_on_next_sysref_arm, .sysref_in,
   .cgs_start_request, .link_sync_armed, .sysref_sync_armed, .nco_sync_pulse
);

/* tb/ddc_link_partner.sv */
/*
 Link receiver and SYSREF source facing the down-converter core.
 Assumes clk_sys from the bench; tasks are called by the bench.
*/
`timescale 1ns/100ps
module ddc_link_partner
(
   input  wire logic clk_sys,     // Device clock
   input  wire logic sysref_free, // Run SYSREF continuously
   output logic      se_sync_n,   // Single-ended sync pin
   output logic      diff_sync_n, // Differential sync pin
   output logic      sysref       // SYSREF pin
);
   logic [3:0] phase = 4'h0;

   initial
   begin
      se_sync_n = 1'b1;
      diff_sync_n = 1'b1;
      sysref = 1'b0;
   end

   // Unused pin idles high, as its pull-up would leave it
   task automatic drive_sync(input logic sel, input logic level);
      @(posedge clk_sys);
      se_sync_n <= sel ? 1'b1 : level;
      diff_sync_n <= sel ? level : 1'b1;
   endtask

   task automatic sysref_set(input logic level);
      @(posedge clk_sys);
      sysref <= level;
   endtask

   // Long period so the arm write fits between two rising edges
   always @(posedge clk_sys)
      if (sysref_free)
      begin
         phase <= phase + 4'h1;
         sysref <= phase[3];
      end
endmodule

/* tb/ddc_nco_and_decimation_tb.sv */
/*
 Self-checking bench of ddc_core: bypass, buffer stall, sync methods
 and decimation rates. Assumes ddc_pkg and the partner model.
*/
`timescale 1ns/100ps
module ddc_nco_and_decimation_tb;
   import ddc_pkg::*;
   logic          clk_sys = 1'b0;
   logic          sys_rst = 1'b1;
   logic          clk_en = 1'b1;
   logic [11:0]   adc_sample = 12'h0;
   logic          adc_valid = 1'b0;
   logic [2:0]    decim_mode = 3'h0;
   logic [127:0]  nco_freq_word_a = 128'h40000000_ffffffff_80000000_01000000;
   logic [63:0]   nco_phase_offset_a = 64'h4000_8000_0001_ffff;
   logic [15:0]   rational_step_divider = 16'h0;
   logic [1:0]    nco_select = 2'h0;
   logic          sync_on_link_init_enable = 1'b0;
   logic          sync_on_next_sysref_arm = 1'b0;
   logic          serial_link_enable = 1'b0;
   logic          sync_use_differential = 1'b0;
   logic          out_ready = 1'b1;
   logic          sysref_free = 1'b0;
   logic          adc_ready, out_valid, cgs_start_request, nco_sync_pulse;
   logic          link_sync_armed, sysref_sync_armed, sysref_in;
   logic          single_ended_sync_input_n, differential_sync_input_n;
   logic [14:0]   out_i, out_q;
   int            n_errors = 0;
   int            checks = 0;

   ddc_core dut
   (
      .clk_sys, .sys_rst, .clk_en, .adc_sample, .adc_valid, .adc_ready,
      .decim_mode, .nco_freq_word_a, .nco_phase_offset_a,
      .rational_step_divider, .nco_select, .sync_on_link_init_enable,
      .sync_on_next_sysref_arm, .serial_link_enable,
      .single_ended_sync_input_n, .differential_sync_input_n,
      .sync_use_differential, .sysref_in, .out_i, .out_q, .out_valid,
      .out_ready, .cgs_start_request, .link_sync_armed,
      .sysref_sync_armed, .nco_sync_pulse
   );

   ddc_link_partner u_link
   (
      .clk_sys, .sysref_free, .se_sync_n(single_ended_sync_input_n),
      .diff_sync_n(differential_sync_input_n), .sysref(sysref_in)
   );

   always #25 clk_sys = ~clk_sys;

   task automatic chk(input string what, input logic [14:0] exp,
                      input logic [14:0] got);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_pulse(input int lim, output logic [14:0] cnt);
      cnt = 15'h0;
      repeat (lim)
      begin
         @(posedge clk_sys);
         if (nco_sync_pulse === 1'b1)
            cnt++;
      end
   endtask

   task automatic push(input logic [11:0] s);
      @(posedge clk_sys);
      adc_valid <= 1'b1;
      adc_sample <= s;
      @(posedge clk_sys);
      for (int k = 0; k < 20 && adc_ready !== 1'b1; k++)
         @(posedge clk_sys);
      adc_valid <= 1'b0;
   endtask

   // Compares the word handed over at the current edge
   task automatic pop(input logic [14:0] ei, input logic [14:0] eq);
      for (int k = 0; k < 20 && out_valid !== 1'b1; k++)
         @(posedge clk_sys);
      chk("out_i", ei, out_i);
      chk("out_q", eq, out_q);
      @(posedge clk_sys);
   endtask

   task automatic t_bypass;
      logic [11:0] v [4] = '{12'h7ff, 12'h800, 12'h001, 12'hfff};
      decim_mode <= 3'h0;
      foreach (v[k])
      begin
         push(v[k]);
         pop({{3{v[k][11]}}, v[k]}, 15'h0);
      end
   endtask

   // Sink stalls until the input side refuses, then all words come out
   task automatic t_stall;
      logic [14:0] n;
      n = 15'h0;
      out_ready <= 1'b0;
      adc_valid <= 1'b1;
      adc_sample <= 12'h1;
      repeat (16)
      begin
         @(posedge clk_sys);
         if (adc_ready === 1'b1)
         begin
            n++;
            adc_sample <= n[11:0] + 12'h1;
         end
      end
      chk("adc_ready", 15'h0, {14'h0, adc_ready});
      adc_valid <= 1'b0;
      out_ready <= 1'b1;
      @(posedge clk_sys);
      for (logic [14:0] k = 15'h1; k <= n; k++)
         pop(k, 15'h0);
      repeat (4) @(posedge clk_sys);
      chk("out_valid", 15'h0, {14'h0, out_valid});
   endtask

   task automatic t_link;
      logic [14:0] c;
      for (int p = 0; p < 2; p++)
      begin
         sync_use_differential <= p[0];
         sync_on_link_init_enable <= 1'b1;
         serial_link_enable <= 1'b0;
         nco_freq_word_a[31:0] <= 32'h0a3d70a4;
         u_link.drive_sync(p[0], 1'b1);
         serial_link_enable <= 1'b1;
         u_link.drive_sync(p[0], 1'b0);
         repeat (5) @(posedge clk_sys);
         chk("link_sync_armed", 15'h1, {14'h0, link_sync_armed});
         chk("cgs_start_request", 15'h1, {14'h0, cgs_start_request});
         u_link.drive_sync(p[0], 1'b1);
         wait_pulse(8, c);
         chk("link pulses", 15'h1, c);
         chk("link_sync_armed", 15'h0, {14'h0, link_sync_armed});
      end
      sync_on_link_init_enable <= 1'b0;
      u_link.drive_sync(1'b1, 1'b0);
      u_link.drive_sync(1'b1, 1'b1);
      wait_pulse(8, c);
      chk("unarmed link pulses", 15'h0, c);
   endtask

   task automatic t_sysref;
      logic [14:0] c;
      @(posedge clk_sys);
      sync_on_next_sysref_arm <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("sysref_sync_armed", 15'h1, {14'h0, sysref_sync_armed});
      u_link.sysref_set(1'b1);
      wait_pulse(12, c);
      chk("sysref pulses", 15'h1, c);
      u_link.sysref_set(1'b0);
      sync_on_next_sysref_arm <= 1'b0;
      sysref_free <= 1'b1;
      wait_pulse(48, c);
      chk("unarmed sysref pulses", 15'h0, c);
      for (int k = 0; k < 20 && sysref_in !== 1'b1; k++)
         @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      sync_on_next_sysref_arm <= 1'b1;
      wait_pulse(24, c);
      chk("free sysref pulses", 15'h1, c);
   endtask

   // One output per factor inputs, counted once the stages are full
   task automatic t_decim;
      int nin;
      int nout;
      int f;
      for (int m = 1; m <= 4; m++)
      begin
         f = 2 << m;
         decim_mode <= m[2:0];
         nco_select <= m[1:0];
         rational_step_divider <= (m == 2) ? 16'h0780 : 16'h0;
         nin = 0;
         nout = 0;
         adc_valid <= 1'b1;
         adc_sample <= 12'h100;
         while (nin < 2048 + 16 * f)
         begin
            @(posedge clk_sys);
            if (adc_ready === 1'b1)
               nin++;
            if (out_valid === 1'b1 && nin > 2048)
               nout++;
         end
         adc_valid <= 1'b0;
         chk("rate ok", 15'h1, 15'(nout >= 15 && nout <= 17));
         repeat (300) @(posedge clk_sys);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge clk_sys);
      n_errors++;
      finish_test();
   end

   initial
   begin
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_bypass();
      t_stall();
      t_link();
      t_sysref();
      t_decim();
      finish_test();
   end
endmodule
